// file: src/vsp_defines.svh
// Constants shared by both ends of the video stream port
`ifndef VSP_DEFINES_SVH
`define VSP_DEFINES_SVH

// Input ready stays low this many cycles after a line end is taken
`define VSP_FLUSH_CYCLES 3'h7
// Width of the flush down-counter
`define VSP_FLUSH_W 3
// Width of the external interrupt controller vector
`define VSP_IRQ_VEC_W 6
// Bit positions inside the external interrupt controller vector
`define VSP_VEC_FRAME_START 0
`define VSP_VEC_LINE_END 1
`define VSP_VEC_FLUSH_BUSY 2
`define VSP_VEC_OUT_STALL 3
// Width of the pixel and line counters
`define VSP_CNT_W 16

`endif

// file: src/vsp_pkg.sv
// Types shared by both ends of the video stream port
package vsp_pkg;

   // Output pixel source of the core
   typedef enum logic [0:0]
   {
      MODE_PASS = 1'b0,
      MODE_RAMP = 1'b1
   } mode_type;

   // States of the pixel source
   typedef enum logic [0:0]
   {
      SRC_IDLE = 1'b0,
      SRC_SEND = 1'b1
   } src_state_type;

endpackage

// file: src/vsp_stream_if.sv
// Interface joining the core to its upstream source and downstream sink
`timescale 1ns/1ps
`default_nettype none

interface vsp_stream_if
#(
   parameter int DATA_W = 24
);
   // Input stream, source to core
   logic [DATA_W-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic in_frame_start;
   logic in_line_end_marker;
   // Output stream, core to sink
   logic [DATA_W-1:0] out_data;
   logic out_valid;
   logic out_ready;
   logic out_frame_start;
   logic out_line_end_marker;

   // Core end
   modport core
   (
      input in_data,
      input in_valid,
      input in_frame_start,
      input in_line_end_marker,
      output in_ready,
      output out_data,
      output out_valid,
      output out_frame_start,
      output out_line_end_marker,
      input out_ready
   );

   // Source and sink end
   modport partner
   (
      output in_data,
      output in_valid,
      output in_frame_start,
      output in_line_end_marker,
      input in_ready,
      input out_data,
      input out_valid,
      input out_frame_start,
      input out_line_end_marker,
      output out_ready
   );
endinterface

`default_nettype wire

// file: src/vsp_partner.sv
// Upstream pixel source and downstream pixel sink for the core
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.svh"

module vsp_partner
#(
   parameter int COMP_W = 8,
   parameter int NCOMP = 3,
   parameter int DATA_W = 24,
   parameter int LINE_PIX = 8,
   parameter int LINES = 4
)
(
   // Clock, enable and reset
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_rst,
   // Stream link
   vsp_stream_if.partner io_stream,
   // Source control
   input wire logic i_src_run,
   output logic o_src_busy,
   // Sink control and captured pixels
   input wire logic i_sink_ready,
   output logic [DATA_W-1:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_rx_frame_start,
   output logic o_rx_line_end
);
   localparam int PIX_W = NCOMP * COMP_W;

   vsp_pkg::src_state_type state_reg;
   logic [`VSP_CNT_W-1:0] pix_reg;
   logic [`VSP_CNT_W-1:0] line_reg;
   logic [`VSP_CNT_W-1:0] pix_next;
   logic [`VSP_CNT_W-1:0] line_next;
   logic [DATA_W-1:0] data_reg;
   logic valid_reg;
   logic sof_reg;
   logic eol_reg;
   logic ready_reg;
   logic advance;
   logic load;
   logic frame_last;
   logic [PIX_W-1:0] pix_word;

   ////////////////////////////////////////////////////////////////////////
   // Source

   // Transfer counts only with enable, ready and valid all high
   // RULE9 source completion
   assign advance = i_ce && valid_reg && io_stream.in_ready;
   assign frame_last = (pix_reg == `VSP_CNT_W'(LINE_PIX - 1)) &&
                       (line_reg == `VSP_CNT_W'(LINES - 1));
   assign load = (state_reg == vsp_pkg::SRC_IDLE) || advance;

   // Position of the pixel to present next
   always_comb
   begin
      pix_next = pix_reg;
      line_next = line_reg;
      if (advance)
      begin
         if (pix_reg == `VSP_CNT_W'(LINE_PIX - 1))
         begin
            pix_next = '0;
            line_next = frame_last ? '0 : line_reg + 1'b1;
         end
         else
         begin
            pix_next = pix_reg + 1'b1;
         end
      end
   end

   // Each component carries the pixel index plus its component index
   genvar k;
   generate
      for (k = 0; k < NCOMP; k++)
      begin : g_src_comp
         assign pix_word[k*COMP_W +: COMP_W] = COMP_W'(pix_next + k);
      end
   endgenerate

   // Offer and hold pixels until taken
   // RULE12 never withdraw offer
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_reg <= vsp_pkg::SRC_IDLE;
         valid_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         case (state_reg)
            vsp_pkg::SRC_IDLE:
               if (i_src_run)
               begin
                  state_reg <= vsp_pkg::SRC_SEND;
                  valid_reg <= 1'b1;
               end
            vsp_pkg::SRC_SEND:
               // RULE13 back to back
               if (advance && frame_last && !i_src_run)
               begin
                  state_reg <= vsp_pkg::SRC_IDLE;
                  valid_reg <= 1'b0;
               end
            default:
            begin
               state_reg <= vsp_pkg::SRC_IDLE;
               valid_reg <= 1'b0;
            end
         endcase
      end
   end

   // Pixel fields change only when idle or after a completed transfer
   // RULE11 stable while offered
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pix_reg <= '0;
         line_reg <= '0;
         data_reg <= '0;
         sof_reg <= 1'b0;
         eol_reg <= 1'b0;
      end
      else if (i_ce && load)
      begin
         pix_reg <= pix_next;
         line_reg <= line_next;
         // RULE7 zero upper bits
         data_reg <= DATA_W'(pix_word);
         // RULE16 frame and line marks
         sof_reg <= (pix_next == '0) && (line_next == '0);
         // RULE19 last pixel only
         eol_reg <= pix_next == `VSP_CNT_W'(LINE_PIX - 1);
      end
   end

   assign io_stream.in_data = data_reg;
   assign io_stream.in_valid = valid_reg;
   assign io_stream.in_frame_start = sof_reg;
   assign io_stream.in_line_end_marker = eol_reg;
   assign o_src_busy = valid_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sink

   // Ready registered from the user, independent of valid
   // RULE15 ready independent
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ready_reg <= 1'b0;
      else if (i_ce)
         ready_reg <= i_sink_ready;
   end

   // Capture each completed output transfer
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rx_valid <= 1'b0;
         o_rx_data <= '0;
         o_rx_frame_start <= 1'b0;
         o_rx_line_end <= 1'b0;
      end
      else if (i_ce)
      begin
         o_rx_valid <= io_stream.out_valid && ready_reg;
         if (io_stream.out_valid && ready_reg)
         begin
            o_rx_data <= io_stream.out_data;
            o_rx_frame_start <= io_stream.out_frame_start;
            o_rx_line_end <= io_stream.out_line_end_marker;
         end
      end
      else
      begin
         o_rx_valid <= 1'b0;
      end
   end

   assign io_stream.out_ready = ready_reg;

endmodule

`default_nettype wire

// file: src/vsp_core.sv
// Core end of the video stream port: stream stage with line flush
//
// Notes on behaviour
// RULE1: One clock, enable, reset for everything.
// RULE2: Sample inputs and change outputs on rising edge.
// RULE3: Enable low freezes state and all outputs.
// RULE4: Enable low ignores every input except reset.
// RULE5: Reset acts at next edge, overrides enable.
// RULE6: Stream data widths are whole bytes.
// RULE7: Source zero-fills upper bits of wide components.
// RULE8: Core packs components, zero-fills upper output bits.
// RULE9: Transfer needs ready, valid, enable, no reset.
// RULE10: Only active pixels cross the streams.
// RULE11: Source holds signals stable until transfer completes.
// RULE12: Source never drops or abandons an offer.
// RULE13: Source may continue or pause after transfer.
// RULE14: Sink ready may come before, with, after valid.
// RULE15: Sink should drive ready independent of valid.
// RULE16: User bit marks frame start, last marks line end.
// RULE17: Optional six-bit controller vector and interrupt request.
// RULE18: Frame start marks exactly the first pixel.
// RULE19: Line end marks exactly the last line pixel.
// RULE20: Input ready low seven cycles after each line.
// RULE21: Output valid and markers low during, after reset.
`timescale 1ns/1ps
`default_nettype none
`include "vsp_defines.svh"

module vsp_core
#(
   parameter int COMP_W = 8,
   parameter int NCOMP = 3,
   parameter int DATA_W = 24,
   parameter bit HAS_EXT_IRQ = 1'b1,
   parameter bit HAS_IRQ = 1'b0
)
(
   // Clock, enable and reset
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_rst,
   // Stream link
   vsp_stream_if.core io_stream,
   // Pixel source select
   input wire vsp_pkg::mode_type i_mode,
   // Interrupt outputs
   output logic [`VSP_IRQ_VEC_W-1:0] o_ext_irq_ctrl_vector,
   output logic o_irq
);
   localparam int PIX_W = NCOMP * COMP_W;

   // Output stage
   logic [DATA_W-1:0] out_data_reg;
   logic out_valid_reg;
   logic out_sof_reg;
   logic out_eol_reg;
   // Skid stage, catches a pixel taken while the output stalls
   logic [DATA_W-1:0] skid_data_reg;
   logic skid_valid_reg;
   logic skid_sof_reg;
   logic skid_eol_reg;
   logic skid_valid_next;
   // Input side
   logic in_ready_reg;
   logic in_ready_next;
   logic [`VSP_FLUSH_W-1:0] flush_reg;
   logic [`VSP_FLUSH_W-1:0] flush_next;
   logic [COMP_W-1:0] col_reg;
   // Events
   logic [`VSP_IRQ_VEC_W-1:0] vec_reg;
   logic irq_reg;
   // Handshake terms
   logic accept;
   logic take_out;
   logic out_free;
   logic [PIX_W-1:0] ramp_word;
   logic [DATA_W-1:0] pix_word;

   ////////////////////////////////////////////////////////////////////////
   // Handshake terms

   // RULE10 pixels only
   // RULE9 input transfer
   assign accept = i_ce && io_stream.in_valid && in_ready_reg;
   // RULE14 sink ready any time
   assign take_out = i_ce && out_valid_reg && io_stream.out_ready;
   assign out_free = !out_valid_reg || take_out;

   // Skid holds a pixel only while the output cannot move
   always_comb
   begin
      skid_valid_next = skid_valid_reg;
      if (out_free)
         skid_valid_next = 1'b0;
      else if (accept)
         skid_valid_next = 1'b1;
   end

   // Flush count loads on a taken line end, then counts down
   // RULE20 seven cycle flush
   always_comb
   begin
      flush_next = flush_reg;
      if (accept && io_stream.in_line_end_marker)
         flush_next = `VSP_FLUSH_CYCLES;
      else if (flush_reg != '0)
         flush_next = flush_reg - 1'b1;
   end

   assign in_ready_next = !skid_valid_next && (flush_next == '0);

   ////////////////////////////////////////////////////////////////////////
   // Pixel word

   // Ramp pattern: each component is the column count plus its index
   genvar k;
   generate
      for (k = 0; k < NCOMP; k++)
      begin : g_ramp_comp
         assign ramp_word[k*COMP_W +: COMP_W] = COMP_W'(col_reg + k);
      end
   endgenerate

   // Components packed low, bits above them forced to zero
   // RULE6 whole byte width
   // RULE8 pack and zero-fill
   always_comb
   begin
      if (i_mode == vsp_pkg::MODE_RAMP)
         pix_word = DATA_W'(ramp_word);
      else
         pix_word = DATA_W'(io_stream.in_data[PIX_W-1:0]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Input side

   // Ready and flush count; enable low freezes them
   // RULE1 shared clock, reset
   // RULE5 reset over enable
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         in_ready_reg <= 1'b0;
         flush_reg <= '0;
      end
      // RULE3 freeze on enable
      else if (i_ce)
      begin
         in_ready_reg <= in_ready_next;
         flush_reg <= flush_next;
      end
   end

   // Column within the line, cleared by the line end
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         col_reg <= '0;
      else if (accept)
         col_reg <= io_stream.in_line_end_marker ? '0 : col_reg + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output side

   // Output register moves on when empty or taken
   // RULE21 quiet after reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
         out_sof_reg <= 1'b0;
         out_eol_reg <= 1'b0;
      end
      // RULE4 inputs ignored
      else if (i_ce && out_free)
      begin
         if (skid_valid_reg)
         begin
            out_valid_reg <= 1'b1;
            out_data_reg <= skid_data_reg;
            out_sof_reg <= skid_sof_reg;
            out_eol_reg <= skid_eol_reg;
         end
         else if (accept)
         begin
            out_valid_reg <= 1'b1;
            out_data_reg <= pix_word;
            // RULE18 frame start follows pixel
            out_sof_reg <= io_stream.in_frame_start;
            // RULE19 line end follows pixel
            out_eol_reg <= io_stream.in_line_end_marker;
         end
         else
         begin
            out_valid_reg <= 1'b0;
            out_sof_reg <= 1'b0;
            out_eol_reg <= 1'b0;
         end
      end
   end

   // Skid register fills only when a pixel is taken during a stall
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         skid_valid_reg <= 1'b0;
         skid_data_reg <= '0;
         skid_sof_reg <= 1'b0;
         skid_eol_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         skid_valid_reg <= skid_valid_next;
         if (accept && !out_free)
         begin
            skid_data_reg <= pix_word;
            skid_sof_reg <= io_stream.in_frame_start;
            skid_eol_reg <= io_stream.in_line_end_marker;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt outputs

   // Event vector: frame start and line end pulse one cycle, flush busy and stall are levels; present only when configured
   // RULE17 optional vector
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         vec_reg <= '0;
      else if (i_ce)
      begin
         vec_reg <= '0;
         if (HAS_EXT_IRQ)
         begin
            vec_reg[`VSP_VEC_FRAME_START] <= take_out && out_sof_reg;
            vec_reg[`VSP_VEC_LINE_END] <= take_out && out_eol_reg;
            vec_reg[`VSP_VEC_FLUSH_BUSY] <= flush_next != '0;
            vec_reg[`VSP_VEC_OUT_STALL] <= out_valid_reg && !take_out;
         end
      end
   end

   // Request line: frame start event when the request pin is present
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         irq_reg <= 1'b0;
      else if (i_ce)
         irq_reg <= HAS_IRQ && take_out && out_sof_reg;
   end

   // RULE2 outputs from edge registers
   assign io_stream.in_ready = in_ready_reg;
   assign io_stream.out_data = out_data_reg;
   assign io_stream.out_valid = out_valid_reg;
   assign io_stream.out_frame_start = out_sof_reg;
   assign io_stream.out_line_end_marker = out_eol_reg;
   assign o_ext_irq_ctrl_vector = vec_reg;
   assign o_irq = irq_reg;

endmodule

`default_nettype wire

// file: testbench/vsp_checker.sv
// Concurrent checks on the stream link between core and partner
`timescale 1ns/1ps
`default_nettype none

module vsp_checker
#(
   parameter int DATA_W = 24
)
(
   // Clock, enable and reset
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_rst,
   // Input stream
   input wire logic [DATA_W-1:0] in_data,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic in_frame_start,
   input wire logic in_line_end_marker,
   // Output stream
   input wire logic [DATA_W-1:0] out_data,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic out_frame_start,
   input wire logic out_line_end_marker
);
   default clocking dflt @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // Completed transfers on each side
   logic in_take;
   logic out_take;
   assign in_take = i_ce && in_valid && in_ready;
   assign out_take = i_ce && out_valid && out_ready;

   // Reset level one edge back, for the quiet check after release
   logic past_rst_reg;
   always_ff @(posedge i_clk)
   begin
      past_rst_reg <= i_rst;
   end

   // Handshake, flush, enable and reset checks
   AST_IN_HOLD:
   assert property (in_valid && !in_take |=> in_valid
      && $stable({in_data, in_frame_start, in_line_end_marker}))
      else $error("input offer changed before it was taken");
   AST_OUT_HOLD:
   assert property (out_valid && !out_take |=> out_valid
      && $stable({out_data, out_frame_start, out_line_end_marker}))
      else $error("output pixel changed before it was taken");
   AST_FLUSH:
   assert property (in_take && in_line_end_marker |=> !in_ready [*7])
      else $error("input ready back too early after line end");
   AST_CE_FREEZE:
   assert property (!i_ce |=> $stable({in_ready, in_valid, out_valid,
      out_data, out_frame_start, out_line_end_marker}))
      else $error("link moved while enable low");
   AST_RST_QUIET:
   assert property (disable iff (1'b0) past_rst_reg |-> !in_ready
      && !out_valid && !out_frame_start && !out_line_end_marker)
      else $error("link active right after reset");
   AST_OUT_FWD:
   assert property (in_take && (!out_valid || out_take) |=> out_valid
      && out_frame_start == $past(in_frame_start)
      && out_line_end_marker == $past(in_line_end_marker))
      else $error("taken pixel not forwarded with its markers");
   AST_SKID:
   assert property (out_valid && !out_take && in_take |=> !in_ready)
      else $error("input ready kept high with skid full");
   AST_MARK_VALID:
   assert property (out_frame_start || out_line_end_marker |-> out_valid)
      else $error("marker shown without a pixel");

   // Main scenarios reached
   cover property (in_take && in_line_end_marker);
   cover property (out_valid && !out_take && in_take);
   cover property (out_take && out_frame_start);
endmodule

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench: core and partner joined through the stream link
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // Link widths used throughout the bench
   localparam int DATA_W = 32;
   localparam int COMP_W = 10;
   logic i_clk;
   logic i_ce;
   logic i_rst;
   logic ce_hold;
   logic stall;
   logic ce_gap;
   logic src_run;
   logic sink_ready;
   vsp_pkg::mode_type mode;
   logic [5:0] vec;
   logic irq;
   logic busy;
   logic [31:0] rx_data;
   logic rx_valid;
   logic rx_sof;
   logic rx_eol;
   logic [33:0] rxq[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   int n_sof = 0;
   int n_eol = 0;
   int n_irq = 0;
   int n_busy = 0;
   int n_stall = 0;
   int fl = -1;

   vsp_stream_if #(.DATA_W(DATA_W)) io ();

   vsp_core #(.COMP_W(COMP_W), .DATA_W(DATA_W), .HAS_IRQ(1'b1)) i_vsp_core
   (
      .i_clk(i_clk), .i_ce(i_ce), .i_rst(i_rst), .io_stream(io),
      .i_mode(mode), .o_ext_irq_ctrl_vector(vec), .o_irq(irq)
   );

   vsp_partner #(.COMP_W(COMP_W), .DATA_W(DATA_W)) i_vsp_partner
   (
      .i_clk(i_clk), .i_ce(i_ce), .i_rst(i_rst), .io_stream(io),
      .i_src_run(src_run), .o_src_busy(busy),
      .i_sink_ready(sink_ready), .o_rx_data(rx_data),
      .o_rx_valid(rx_valid), .o_rx_frame_start(rx_sof),
      .o_rx_line_end(rx_eol)
   );

   vsp_checker #(.DATA_W(DATA_W)) i_vsp_checker
   (
      .i_clk(i_clk), .i_ce(i_ce), .i_rst(i_rst),
      .in_data(io.in_data), .in_valid(io.in_valid),
      .in_ready(io.in_ready), .in_frame_start(io.in_frame_start),
      .in_line_end_marker(io.in_line_end_marker),
      .out_data(io.out_data), .out_valid(io.out_valid),
      .out_ready(io.out_ready), .out_frame_start(io.out_frame_start),
      .out_line_end_marker(io.out_line_end_marker)
   );

   // Clock of 40 ns
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Compare one result and count it
   task chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Print the counts and the verdict, then stop
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Send one frame and compare what the sink received
   task run_frame(input string name);
      int p;
      logic [33:0] exp_w;
      rxq.delete();
      n_sof = 0;
      n_eol = 0;
      n_irq = 0;
      n_busy = 0;
      n_stall = 0;
      src_run <= 1'b1;
      while (busy !== 1'b1)
         @(posedge i_clk);
      src_run <= 1'b0;
      while (rxq.size() < 32)
         @(posedge i_clk);
      repeat (12) @(posedge i_clk);
      chk(rxq.size(), 32);
      foreach (rxq[i])
      begin
         p = i % 8;
         exp_w = {i == 0, p == 7, 2'h0, 10'(p + 2), 10'(p + 1), 10'(p)};
         chk(rxq[i], exp_w);
      end
      chk(n_sof, 1);
      chk(n_eol, 4);
      chk(n_irq, 1);
      chk(n_busy, 28);
      chk(n_stall != 0, stall);
      $display("test %s done", name);
   endtask

   // Drive enable and sink readiness from the scenario flags
   always @(posedge i_clk)
   begin
      sink_ready <= stall ? (cycles % 3 == 0) : 1'b1;
      i_ce <= ce_gap ? (cycles % 4 != 3) : ce_hold;
   end

   // Capture sink pixels, vector pulses and flush lengths
   always @(posedge i_clk)
   begin
      // Sink pulse lasts one cycle whatever the enable does
      if (rx_valid === 1'b1)
         rxq.push_back({rx_sof, rx_eol, rx_data});
      if (i_ce === 1'b1)
      begin
         n_sof += int'(vec[0] === 1'b1);
         n_eol += int'(vec[1] === 1'b1);
         n_irq += int'(irq === 1'b1);
         n_busy += int'(vec[2] === 1'b1);
         n_stall += int'(vec[3] === 1'b1);
         if (fl >= 0 && io.in_ready === 1'b1)
         begin
            if (!stall)
               chk(fl, 7);
            fl = -1;
         end
         else if (fl >= 0)
            fl++;
         if ((io.in_valid & io.in_ready & io.in_line_end_marker) === 1'b1)
            fl = 0;
      end
      if (i_rst === 1'b1)
         fl = -1;
   end

   // Cut a hung run short
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   // Main sequence
   initial
   begin
      i_rst = 1'b1;
      ce_hold = 1'b1;
      stall = 1'b0;
      ce_gap = 1'b0;
      src_run = 1'b0;
      mode = vsp_pkg::MODE_PASS;
      repeat (8) @(posedge i_clk);
      chk({io.in_ready, io.out_valid, busy, vec, irq}, 0);
      i_rst <= 1'b0;
      run_frame("pass_through");
      mode <= vsp_pkg::MODE_RAMP;
      stall <= 1'b1;
      run_frame("sink_stall");
      stall <= 1'b0;
      ce_gap <= 1'b1;
      run_frame("enable_gaps");
      ce_gap <= 1'b0;
      // Reset with enable low in mid frame
      src_run <= 1'b1;
      repeat (12) @(posedge i_clk);
      ce_hold <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b1;
      src_run <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk({io.in_ready, io.out_valid, busy, vec, irq}, 0);
      i_rst <= 1'b0;
      ce_hold <= 1'b1;
      $display("test reset_enable_low done");
      run_frame("after_reset");
      summarize();
   end
endmodule

`default_nettype wire
